// ===== verilog/dsk_mapper.sv
`timescale 1ns/1ps

// Operation
// - Each enciphered field uses one keystream segment of 840 bits, index 0 first.
// - Control tail: segment bits 0..39 XOR onto tail bits 8..47 in order.
// - Other tail content: segment bits 0..39 are consumed and dropped.
// - Unprotected B-field: bit i XORs with segment bit i plus 40.
// - Single-subfield: B bits 0..767 get segment 40..807; 808..839 dropped.
// - Multi-subfield: data bits of subfield k get segment 40+80k..103+80k.
// - Multi-subfield: 16 segment bits after each data window are dropped.
// - Check bits and trailing check field always pass through unchanged.
// - Multi layout: ten subfields of 64 data plus 16 check, then 4 bits.
// - Single layout: 768 data bits, 32 check bits, then trailing field.
// - Unprotected layout: all 800 B-field bits are payload.
// - Both segments of one frame form one 1680-bit keystream.
// - Each bearer of a connection is enciphered separately per frame.
// - First field of a frame uses fixed segment, second uses portable.
// - Cipher mode is set per connection and applies to all its bearers.
// - Mode is reported once per connection, on indication and confirmation; the code reports once per exchange, naming modeConn only.
// - Connections of one call or data link share the same cipher mode.
// - Link access content stays clear unless routed to an enciphered connection.
module dsk_mapper
  import dsk_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH_P = dsk_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // Field start request
  input  wire logic                      startValid,
  output logic                           startReady,
  input  wire logic [dsk_pkg::CONN_W-1:0]   startConn,
  input  wire logic [dsk_pkg::BEARER_W-1:0] startBearer,
  input  wire logic                      startFirstField,
  input  wire logic                      startTailCtrl,
  input  wire logic [1:0]                startFormat,
  input  wire logic                      startLinkAccess,
  input  wire logic                      startRoutedToLc,
  // Serial field bits from framing
  input  wire logic                      fieldValid,
  output logic                           fieldReady,
  input  wire logic                      fieldBit,
  // Serial keystream bits from generator
  input  wire logic                      ksValid,
  output logic                           ksReady,
  input  wire logic                      ksBit,
  // Serial mapped field bits out
  output logic                           outValid,
  input  wire logic                      outReady,
  output logic                           outBit,
  output logic                           outLast,
  // Cipher mode change from the mode-control exchange
  input  wire logic                      modeValid,
  input  wire logic [dsk_pkg::CONN_W-1:0]   modeConn,
  input  wire logic [dsk_pkg::NUM_CONN-1:0] modeGroupMask,
  input  wire logic                      modeOn,
  input  wire logic                      modeIsConfirm,
  // Mode report to upper layer
  output logic                           cipherModeIndication,
  output logic                           cipherModeConfirmation,
  output logic [dsk_pkg::CONN_W-1:0]        reportConn,
  output logic                           reportMode,
  // Field status
  output logic                           cipherActive,
  output logic                           portableSegment,
  output logic [dsk_pkg::BEARER_W-1:0]      activeBearer,
  output logic                           frameKeystreamDone
);

  import dsk_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Position decode: bit 1 = keystream bit consumed, bit 0 = keystream applied
  function automatic logic [1:0] map_pos(input logic [POS_W-1:0] pos,
                                         input logic tailCtrl,
                                         input dsk_fmt_t fmt);
    logic [POS_W-1:0] bPos;
    logic [1:0]       res;
    bPos = pos - POS_W'(TAIL_LEN);
    res  = 2'b00;
    if (pos < POS_W'(TAIL_LEN)) begin
      if (pos >= POS_W'(TAIL_KS_FIRST) && pos <= POS_W'(TAIL_KS_LAST)) begin
        res = {1'b1, tailCtrl};
      end
    end else if (bPos < POS_W'(B_LEN)) begin
      case (fmt)
        FMT_UNPROT: res = 2'b11;
        FMT_SINGLE: res = {1'b1, bPos < POS_W'(SINGLE_DATA)};
        FMT_MULTI:  res = {1'b1, (bPos % POS_W'(SUB_LEN)) < POS_W'(SUB_DATA)};
        default:    res = 2'b10;
      endcase
    end
    // Trailing check field past the B-field falls through as 00
    return res;
  endfunction : map_pos

  ////////////////////////////////////////////////////////////////////////////
  // Per-connection cipher mode table
  logic [NUM_CONN-1:0] connMode;

  // One exchange sets the mode for the connection and its call group
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      connMode <= {NUM_CONN{RST_MODE}};
    end else if (modeValid) begin
      for (int c = 0; c < NUM_CONN; c++) begin
        if (modeGroupMask[c] || (CONN_W'(c) == modeConn)) begin
          connMode[c] <= modeOn;
        end
      end
    end
  end

  // Single report per exchange, never per bearer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cipherModeIndication   <= 1'b0;
      cipherModeConfirmation <= 1'b0;
      reportConn             <= '0;
      reportMode             <= RST_MODE;
    end else begin
      cipherModeIndication   <= modeValid && !modeIsConfirm;
      cipherModeConfirmation <= modeValid && modeIsConfirm;
      if (modeValid) begin
        reportConn <= modeConn;
        reportMode <= modeOn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field context
  dsk_state_t       state;
  logic             tailCtrl;
  dsk_fmt_t         fmt;
  logic [POS_W-1:0] takeCnt;
  logic [SEG_W-1:0] ksTakeCnt;
  logic [POS_W-1:0] procCnt;
  logic             fieldHeldV;
  logic             fieldHeld;
  logic             ksHeldV;
  logic             ksHeld;
  logic [1:0]       posMap;
  logic             fifoInReady;
  logic             procStep;
  logic             fieldTake;
  logic             ksTake;
  logic             startTake;
  logic             lastPos;
  logic             cipherNow;
  logic             next_fieldHeldV;
  logic             next_ksHeldV;

  // Clear unless the carrying connection is enciphered
  assign cipherNow = connMode[startConn] && !(startLinkAccess && !startRoutedToLc);
  assign startTake = startValid && startReady;
  assign fieldTake = fieldValid && fieldReady;
  assign ksTake    = ksValid && ksReady;
  assign posMap    = map_pos(procCnt, tailCtrl, fmt);
  assign lastPos   = (procCnt == POS_W'(FIELD_LEN - 1));
  // Clear mode needs no keystream; ciphered needs the held bit where a segment bit is consumed
  assign procStep  = (state == ST_RUN) && fieldHeldV && fifoInReady &&
                     (!(cipherActive && posMap[1]) || ksHeldV);

  // Hold state after this cycle's take and step
  always_comb begin
    next_fieldHeldV = fieldHeldV;
    next_ksHeldV    = ksHeldV;
    if (procStep) begin
      next_fieldHeldV = 1'b0;
      if (cipherActive && posMap[1]) begin
        next_ksHeldV = 1'b0;
      end
    end
    if (fieldTake) begin
      next_fieldHeldV = 1'b1;
    end
    if (ksTake) begin
      next_ksHeldV = 1'b1;
    end
  end

  // Field state machine
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (startTake) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (procStep && lastPos) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Context captured once per field; each bearer field is its own job
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tailCtrl        <= 1'b0;
      fmt             <= FMT_UNPROT;
      cipherActive    <= 1'b0;
      portableSegment <= 1'b0;
      activeBearer    <= '0;
    end else if (startTake) begin
      tailCtrl        <= startTailCtrl;
      fmt             <= dsk_fmt_t'(startFormat);
      cipherActive    <= cipherNow;
      portableSegment <= !startFirstField;
      activeBearer    <= startBearer;
    end
  end

  // Start is accepted only between fields
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      startReady <= 1'b0;
    end else begin
      startReady <= (state == ST_IDLE) && !startTake &&
                    !(state == ST_RUN && procStep && lastPos);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Take counters
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      takeCnt   <= '0;
      ksTakeCnt <= '0;
    end else if (startTake) begin
      takeCnt   <= '0;
      ksTakeCnt <= '0;
    end else begin
      if (fieldTake) begin
        takeCnt <= takeCnt + POS_W'(1);
      end
      if (ksTake) begin
        ksTakeCnt <= ksTakeCnt + SEG_W'(1);
      end
    end
  end

  // Registered readies; one-entry holds absorb the ready latency
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fieldReady <= 1'b0;
      ksReady    <= 1'b0;
    end else begin
      fieldReady <= (state == ST_RUN) && !next_fieldHeldV && !(fieldTake || fieldReady) &&
                    (takeCnt + POS_W'(fieldTake) < POS_W'(FIELD_LEN));
      // Exactly one segment per ciphered field, none in clear mode
      ksReady    <= (state == ST_RUN) && cipherActive && !next_ksHeldV && !(ksTake || ksReady) &&
                    (ksTakeCnt + SEG_W'(ksTake) < SEG_W'(SEG_LEN));
    end
  end

  // Held bits
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fieldHeldV <= 1'b0;
      fieldHeld  <= 1'b0;
      ksHeldV    <= 1'b0;
      ksHeld     <= 1'b0;
    end else begin
      fieldHeldV <= next_fieldHeldV;
      ksHeldV    <= next_ksHeldV;
      if (fieldTake) begin
        fieldHeld <= fieldBit;
      end
      if (ksTake) begin
        ksHeld <= ksBit;
      end
    end
  end

  // Position of the bit being mapped
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      procCnt <= '0;
    end else if (startTake) begin
      procCnt <= '0;
    end else if (procStep) begin
      procCnt <= procCnt + POS_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Concatenated frame keystream count, restarted by the first field
  logic [CAT_W-1:0] catCnt;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      catCnt <= '0;
    end else if (startTake && startFirstField) begin
      catCnt <= '0;
    end else if (ksTake && catCnt != CAT_W'(CONCAT_LEN)) begin
      catCnt <= catCnt + CAT_W'(1);
    end
  end

  // Level high once both segments of the frame were consumed
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      frameKeystreamDone <= 1'b0;
    end else begin
      frameKeystreamDone <= (catCnt == CAT_W'(CONCAT_LEN));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // XOR and output buffering; a stalled drain stalls the mapping
  logic                  mappedBit;
  logic [FIFO_WIDTH-1:0] fifoOut;

  assign mappedBit = fieldHeld ^ (cipherActive && posMap[0] && ksHeld);

  dsk_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH_P)
  ) u_out_fifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .inValid  (procStep),
    .inReady  (fifoInReady),
    .inData   ({lastPos, mappedBit}),
    .outValid (outValid),
    .outReady (outReady),
    .outData  (fifoOut)
  );

  assign outBit  = fifoOut[0];
  assign outLast = fifoOut[1];

endmodule : dsk_mapper

// ===== verilog/dsk_pkg.sv
package dsk_pkg;

  // Field layout: tail of 64 bits, then B-field of 800 bits, then 4-bit trailing check
  localparam int unsigned TAIL_LEN       = 64;
  localparam int unsigned TAIL_KS_FIRST  = 8;
  localparam int unsigned TAIL_KS_LAST   = 47;
  localparam int unsigned B_LEN          = 800;
  localparam int unsigned X_LEN          = 4;
  localparam int unsigned FIELD_LEN      = TAIL_LEN + B_LEN + X_LEN;

  // Keystream segment layout
  localparam int unsigned SEG_LEN        = 840;
  localparam int unsigned SEG_TAIL_LEN   = 40;
  localparam int unsigned CONCAT_LEN     = 1680;

  // Protected formats
  localparam int unsigned SINGLE_DATA    = 768;
  localparam int unsigned SINGLE_CHECK   = 32;
  localparam int unsigned SUB_LEN        = 80;
  localparam int unsigned SUB_DATA       = 64;
  localparam int unsigned SUB_CHECK      = 16;
  localparam int unsigned NUM_SUB        = 10;

  // Counter widths
  localparam int unsigned POS_W          = 10;
  localparam int unsigned SEG_W          = 10;
  localparam int unsigned CAT_W          = 11;

  // Sizing of the table of connections and bearers
  localparam int unsigned NUM_CONN       = 4;
  localparam int unsigned CONN_W         = 2;
  localparam int unsigned BEARER_W       = 4;

  // Output FIFO
  localparam int unsigned FIFO_WIDTH     = 2;
  localparam int unsigned FIFO_DEPTH     = 16;

  // Reset values
  localparam logic        RST_MODE       = 1'b0;

  // B-field formats
  typedef enum logic [1:0] {
    FMT_UNPROT = 2'b00,
    FMT_SINGLE = 2'b01,
    FMT_MULTI  = 2'b10
  } dsk_fmt_t;

  // Field processing states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } dsk_state_t;

endpackage : dsk_pkg

// ===== verilog/dsk_fifo.sv
`timescale 1ns/1ps

module dsk_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWrite;
  logic             doRead;
  logic             memValid;

  ////////////////////////////////////////////////////////////////////////////
  // Honest full and empty from the occupancy count
  assign inReady  = (count != (AW+1)'(DEPTH));
  assign memValid = (count != '0);
  assign doWrite  = inValid && inReady;
  // Refill the output register whenever it is empty or being drained
  assign doRead   = memValid && (!outValid || outReady);

  // Storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers wrap on the power-of-two depth
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + AW'(1);
      end
      if (doRead) begin
        rdPtr <= rdPtr + AW'(1);
      end
    end
  end

  // Occupancy
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count <= '0;
    end else if (doWrite && !doRead) begin
      count <= count + (AW+1)'(1);
    end else if (doRead && !doWrite) begin
      count <= count - (AW+1)'(1);
    end
  end

  // Output register so the drain side sees flip-flops only; adds one word of slack
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      outValid <= 1'b0;
      outData  <= '0;
    end else if (doRead) begin
      outValid <= 1'b1;
      outData  <= mem[rdPtr];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end

endmodule : dsk_fifo

// ===== tb/dsk_partner_model.sv
`timescale 1ns/1ps

module dsk_partner_model (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_b,
  // Framing side
  output logic        fieldValid,
  input  wire logic   fieldReady,
  output logic        fieldBit,
  // Keystream side
  output logic        ksValid,
  input  wire logic   ksReady,
  output logic        ksBit,
  output logic [15:0] ksTaken
);
  logic [9:0] fieldPos;

  ////////////////////////////////////////////////////////////////////////////////
  // Field position, tail then B-field then trailing check, 868 bits a field
  always_ff @(posedge clk) begin
    if (!rst_b) fieldPos <= 10'h000;
    else if (fieldValid && fieldReady) fieldPos <= (fieldPos == 10'h363) ? 10'h000 : fieldPos + 10'h001;
  end

  // One running stream, so both segments of a frame follow back to back
  always_ff @(posedge clk) begin
    if (!rst_b) ksTaken <= 16'h0000;
    else if (ksValid && ksReady) ksTaken <= ksTaken + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Always offering; a bit changes only at the edge that takes it
  assign fieldValid = rst_b;
  assign ksValid    = rst_b;
  assign fieldBit   = fieldPos[0] ^ fieldPos[2] ^ fieldPos[5];
  assign ksBit      = ksTaken[0] ^ ksTaken[1] ^ ksTaken[4];
endmodule : dsk_partner_model

// ===== tb/dsk_checker.sv
`timescale 1ns/1ps

module dsk_checker
  import dsk_pkg::*;
(
  // Clock and reset
  input wire logic                          clk,
  input wire logic                          rst_b,
  // Start and streams
  input wire logic                          startValid,
  input wire logic                          startReady,
  input wire logic                          startFirstField,
  input wire logic [dsk_pkg::BEARER_W-1:0] startBearer,
  input wire logic                          fieldReady,
  input wire logic                          ksValid,
  input wire logic                          ksReady,
  input wire logic                          outValid,
  input wire logic                          outReady,
  input wire logic                          outBit,
  input wire logic                          outLast,
  // Mode change and report
  input wire logic                          modeValid,
  input wire logic [dsk_pkg::CONN_W-1:0]   modeConn,
  input wire logic                          modeOn,
  input wire logic                          modeIsConfirm,
  input wire logic                          cipherModeIndication,
  input wire logic                          cipherModeConfirmation,
  input wire logic                          reportMode,
  // Field status
  input wire logic                          cipherActive,
  input wire logic                          portableSegment,
  input wire logic [dsk_pkg::BEARER_W-1:0] activeBearer,
  input wire logic                          frameKeystreamDone
);
  wire take = startValid && startReady;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////////
  // Mode report, one pulse per change for the whole connection
  property p_ind;
    modeValid && !modeIsConfirm |=> cipherModeIndication && !cipherModeConfirmation && reportMode == $past(modeOn);
  endproperty
  a_ind: assert property (p_ind) else $error("Indication pulse wrong");
  property p_cfm;
    modeValid && modeIsConfirm |=> cipherModeConfirmation && !cipherModeIndication && reportMode == $past(modeOn);
  endproperty
  a_cfm: assert property (p_cfm) else $error("Confirmation pulse wrong");
  property p_quiet;
    !modeValid |=> !cipherModeIndication && !cipherModeConfirmation;
  endproperty
  a_quiet: assert property (p_quiet) else $error("Report pulse without change");
  // Clear fields never pull keystream
  property p_clear;
    !cipherActive |-> !ksReady;
  endproperty
  a_clear: assert property (p_clear) else $error("Keystream taken in clear");
  property p_start;
    take |=> !startReady ##1 fieldReady;
  endproperty
  a_start: assert property (p_start) else $error("Field start answer wrong");
  property p_status;
    take |=> activeBearer == $past(startBearer) && portableSegment == !$past(startFirstField);
  endproperty
  a_status: assert property (p_status) else $error("Bearer or segment label wrong");
  property p_ksone;
    ksValid && ksReady |=> !ksReady;
  endproperty
  a_ksone: assert property (p_ksone) else $error("Keystream ready held");
  property p_hold;
    outValid && !outReady |=> outValid && $stable(outBit) && $stable(outLast);
  endproperty
  a_hold: assert property (p_hold) else $error("Output changed while stalled");
  property p_done;
    $fell(frameKeystreamDone) |-> $past(take && startFirstField) || $past(take && startFirstField, 2);
  endproperty
  a_done: assert property (p_done) else $error("Frame keystream flag dropped early");

  // Main scenarios
  c_cfm: cover property (modeValid && modeIsConfirm);
  c_ks: cover property (ksValid && ksReady);
  c_last: cover property (outValid && outReady && outLast);
endmodule : dsk_checker

bind dsk_mapper dsk_checker u_chk (
  .clk(clk), .rst_b(rst_b), .startValid(startValid), .startReady(startReady),
  .startFirstField(startFirstField), .startBearer(startBearer), .fieldReady(fieldReady),
  .ksValid(ksValid), .ksReady(ksReady), .outValid(outValid), .outReady(outReady), .outBit(outBit),
  .outLast(outLast), .modeValid(modeValid), .modeConn(modeConn), .modeOn(modeOn),
  .modeIsConfirm(modeIsConfirm), .cipherModeIndication(cipherModeIndication),
  .cipherModeConfirmation(cipherModeConfirmation), .reportMode(reportMode), .cipherActive(cipherActive),
  .portableSegment(portableSegment), .activeBearer(activeBearer), .frameKeystreamDone(frameKeystreamDone)
);

// ===== tb/double_slot_keystream_xor_tb.sv
`timescale 1ns/1ps

module double_slot_keystream_xor_tb;
  import dsk_pkg::*;
  logic                clk, rst_b, startValid, startReady, startFirstField, startTailCtrl;
  logic                startLinkAccess, startRoutedToLc, fieldValid, fieldReady, fieldBit;
  logic                ksValid, ksReady, ksBit, outValid, outReady, outBit, outLast;
  logic                modeValid, modeOn, modeIsConfirm, cipherModeIndication, cipherModeConfirmation;
  logic                reportMode, cipherActive, portableSegment, frameKeystreamDone;
  logic [CONN_W-1:0]   startConn, modeConn, reportConn;
  logic [BEARER_W-1:0] startBearer, activeBearer;
  logic [1:0]          startFormat;
  logic [NUM_CONN-1:0] modeGroupMask;
  logic [15:0]         ksTaken;
  int                  errCount = 0;
  int                  testsRun = 0;

  dsk_mapper u_dut (.clk(clk), .rst_b(rst_b), .startValid(startValid), .startReady(startReady),
    .startConn(startConn), .startBearer(startBearer), .startFirstField(startFirstField),
    .startTailCtrl(startTailCtrl), .startFormat(startFormat), .startLinkAccess(startLinkAccess),
    .startRoutedToLc(startRoutedToLc), .fieldValid(fieldValid), .fieldReady(fieldReady),
    .fieldBit(fieldBit), .ksValid(ksValid), .ksReady(ksReady), .ksBit(ksBit), .outValid(outValid),
    .outReady(outReady), .outBit(outBit), .outLast(outLast), .modeValid(modeValid), .modeConn(modeConn),
    .modeGroupMask(modeGroupMask), .modeOn(modeOn), .modeIsConfirm(modeIsConfirm),
    .cipherModeIndication(cipherModeIndication), .cipherModeConfirmation(cipherModeConfirmation),
    .reportConn(reportConn), .reportMode(reportMode), .cipherActive(cipherActive),
    .portableSegment(portableSegment), .activeBearer(activeBearer), .frameKeystreamDone(frameKeystreamDone));

  dsk_partner_model u_far (.clk(clk), .rst_b(rst_b), .fieldValid(fieldValid), .fieldReady(fieldReady),
    .fieldBit(fieldBit), .ksValid(ksValid), .ksReady(ksReady), .ksBit(ksBit), .ksTaken(ksTaken));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare helpers and the expected mapping
  task chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic app(int p, logic t, logic [1:0] m);
    int b;
    b = p - 64;
    if (p >= 8 && p <= 47) return t;
    if (b < 0 || b > 799) return 1'b0;
    case (m)
      2'h0: return 1'b1;
      2'h1: return b < 768;
      2'h2: return b % 80 < 64;
      default: return 1'b0;
    endcase
  endfunction : app

  // Drives one field; the sink stalls now and then, and long on first fields to fill the FIFO
  task runField(input logic [1:0] c, input logic f, t, input logic [1:0] m, input logic la, rt, ci);
    int p;
    int n;
    int base;
    logic e;
    base = ksTaken;
    p = 0;
    n = 0;
    {startConn, startBearer, startFirstField, startTailCtrl} = {c, c, m, f, t};
    {startFormat, startLinkAccess, startRoutedToLc, startValid} = {m, la, rt, 1'b1};
    do begin
      @(posedge clk);
      n++;
    end while (startReady !== 1'b1 && n < 50);
    #1 startValid = 1'b0;
    chk(cipherActive, ci);
    chk(portableSegment, !f);
    chk(activeBearer, {c, m});
    n = 0;
    while (p < FIELD_LEN && n < 20000) begin
      @(posedge clk);
      n++;
      if (outValid === 1'b1 && outReady === 1'b1) begin
        e = (p[0] ^ p[2] ^ p[5]) ^ (ci && app(p, t, m) && kb(base + ((p < 48) ? p - 8 : p - 24)));
        chk(outBit, e);
        chk(outLast, p == 867);
        p++;
      end
      #1 outReady = (n % 7 != 0) && !(f && n > 100 && n < 300);
    end
    chk(p, FIELD_LEN);
    chk(ksTaken - 16'(base), ci ? 16'h0348 : 16'h0000);
  endtask : runField

  function automatic logic kb(int i);
    return i[0] ^ i[1] ^ i[4];
  endfunction : kb

  task setMode(input logic [1:0] c, input logic [3:0] gm, input logic on, cf);
    {modeConn, modeGroupMask, modeOn, modeIsConfirm, modeValid} = {c, gm, on, cf, 1'b1};
    @(posedge clk);
    #1 modeValid = 1'b0;
    chk(cf ? cipherModeConfirmation : cipherModeIndication, 1'b1);
    chk({reportConn, reportMode}, {c, on});
  endtask : setMode

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task testClear();
    setMode(2'h0, 4'h0, 1'b0, 1'b0);
    runField(2'h0, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0);
    $display("testClear done");
  endtask : testClear

  // Confirmation on one connection carries its call partner along, not a stranger
  task testModes();
    setMode(2'h0, 4'h2, 1'b1, 1'b1);
    runField(2'h1, 1'b1, 1'b0, 2'h1, 1'b0, 1'b0, 1'b1);
    runField(2'h2, 1'b1, 1'b1, 2'h2, 1'b0, 1'b0, 1'b0);
    $display("testModes done");
  endtask : testModes

  // Formats in first/second pairs; the frame flag rises only after both segments
  task testFormats();
    for (int m = 0; m < 4; m++) begin
      runField(2'h0, !m[0], m[0], 2'(m), 1'b0, 1'b0, 1'b1);
      chk(frameKeystreamDone, m[0]);
    end
    $display("testFormats done");
  endtask : testFormats

  task testLink();
    runField(2'h0, 1'b1, 1'b1, 2'h2, 1'b1, 1'b0, 1'b0);
    runField(2'h0, 1'b0, 1'b1, 2'h0, 1'b1, 1'b1, 1'b1);
    $display("testLink done");
  endtask : testLink

  task print_verdict();
    $display("Comparisons %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, main sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    {rst_b, startValid, startConn, startBearer, startFirstField, startTailCtrl, startFormat} = '0;
    {startLinkAccess, startRoutedToLc, modeValid, modeConn, modeGroupMask, modeOn, modeIsConfirm} = '0;
    outReady = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    testClear();
    testModes();
    testFormats();
    testLink();
    print_verdict();
  end

  // Nine fields at about two cycles a bit stay well inside this span
  initial begin
    #250000;
    errCount++;
    print_verdict();
  end
endmodule : double_slot_keystream_xor_tb
